// ==== hw/interval_timebase_timer.v ====
// Purpose: Interval time-base timer with AXI4-Lite register access
// Assumes: aclk is the main clock; count pulse is every second enabled edge
// Notes: Control register sits at byte address 4 x index 0x00a
`timescale 1ns/1ns
`include "interval_timer_map.vh"

module interval_timebase_timer (
  // Clock, reset, enable
  input wire aclk,
  input wire aresetn,
  input wire clk_en,
  // System state
  input wire main_clk_running,
  input wire power_on_clear,
  input wire mode_clear_req,
  input wire rmw_read,
  // AXI4-Lite write address and data
  input wire [11:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // AXI4-Lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read
  input wire [11:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Outputs to neighbours
  output reg interval_irq,
  output reg counter_clear_strobe,
  output reg wd_counter_clear,
  output reg wd_tap_clk,
  output reg [15:0] tap_clks
);

  reg [23:0] count_q;
  reg [23:0] count_d;
  reg half_q;
  reg interval_flag_q;
  reg interval_irq_enable_q;
  reg [3:0] interval_select_q;
  reg wd_clock_select_hi_q;
  reg wd_clock_select_lo_q;
  reg aw_got_q;
  reg w_got_q;
  reg [11:0] awaddr_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;

  wire wr_fire;
  wire wr_ctrl;
  wire wr_wd;
  wire sw_clear;
  wire hw_clear;
  wire any_clear;
  wire count_tick;
  reg tap_now;
  reg tap_next;
  wire tap_fall;
  wire wd_sel_tbt;
  wire flag_wr_zero;

  assign wr_fire = aw_got_q && w_got_q && !s_axi_bvalid;
  assign wr_ctrl = wr_fire && (awaddr_q[11:2] == `ITB_CTRL_ADDR >> 2) &&
                   wstrb_q[0];
  assign wr_wd = wr_fire && (awaddr_q[11:2] == `ITB_WD_SEL_ADDR >> 2) &&
                 wstrb_q[0];
  assign sw_clear = wr_ctrl && wdata_q[`ITB_BIT_CLR];
  assign hw_clear = !main_clk_running || power_on_clear || mode_clear_req;
  assign any_clear = sw_clear || hw_clear;
  // Count pulse at half the main clock
  assign count_tick = half_q && main_clk_running;
  // Selected tap falls on a count pulse
  assign tap_fall = count_tick && tap_now && !tap_next;
  assign wd_sel_tbt = !wd_clock_select_hi_q;
  assign flag_wr_zero = wr_ctrl && !wdata_q[`ITB_BIT_FLAG];

  // Sleep and timebase standby keep the main clock, so counting goes on
  always @* begin
    count_d = count_q;
    if (any_clear) begin
      count_d = `ITB_CNT_RESET;
    end else if (count_tick) begin
      count_d = count_q - 24'h000001;
    end
  end

  // Tap select: code 0..15 picks counter bit 8..23
  always @* begin
    tap_now = 1'b0;
    tap_next = 1'b0;
    case (interval_select_q)
      4'h0: begin
        tap_now = count_q[8];
        tap_next = count_d[8];
      end
      4'h1: begin
        tap_now = count_q[9];
        tap_next = count_d[9];
      end
      4'h2: begin
        tap_now = count_q[10];
        tap_next = count_d[10];
      end
      4'h3: begin
        tap_now = count_q[11];
        tap_next = count_d[11];
      end
      4'h4: begin
        tap_now = count_q[12];
        tap_next = count_d[12];
      end
      4'h5: begin
        tap_now = count_q[13];
        tap_next = count_d[13];
      end
      4'h6: begin
        tap_now = count_q[14];
        tap_next = count_d[14];
      end
      4'h7: begin
        tap_now = count_q[15];
        tap_next = count_d[15];
      end
      4'h8: begin
        tap_now = count_q[16];
        tap_next = count_d[16];
      end
      4'h9: begin
        tap_now = count_q[17];
        tap_next = count_d[17];
      end
      4'ha: begin
        tap_now = count_q[18];
        tap_next = count_d[18];
      end
      4'hb: begin
        tap_now = count_q[19];
        tap_next = count_d[19];
      end
      4'hc: begin
        tap_now = count_q[20];
        tap_next = count_d[20];
      end
      4'hd: begin
        tap_now = count_q[21];
        tap_next = count_d[21];
      end
      4'he: begin
        tap_now = count_q[22];
        tap_next = count_d[22];
      end
      default: begin
        tap_now = count_q[23];
        tap_next = count_d[23];
      end
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      count_q <= `ITB_CNT_RESET;
      half_q <= 1'b0;
      interval_flag_q <= 1'b0;
      interval_irq_enable_q <= 1'b0;
      interval_select_q <= 4'h0;
      wd_clock_select_hi_q <= 1'b0;
      wd_clock_select_lo_q <= 1'b0;
      interval_irq <= 1'b0;
      counter_clear_strobe <= 1'b0;
      wd_counter_clear <= 1'b0;
      wd_tap_clk <= 1'b1;
      tap_clks <= 16'hffff;
    end else if (clk_en) begin
      count_q <= count_d;
      // Divider phase restarts with the counter
      half_q <= any_clear ? 1'b0 : (main_clk_running ? !half_q : half_q);
      // Set on tap underflow unless cleared in the same cycle
      if (tap_fall && !sw_clear && !hw_clear) begin
        interval_flag_q <= 1'b1;
      end else if (flag_wr_zero) begin
        // Zero write clears, one write ignored
        interval_flag_q <= 1'b0;
      end
      if (wr_ctrl) begin
        interval_irq_enable_q <= wdata_q[`ITB_BIT_IE];
        interval_select_q <= wdata_q[`ITB_SEL_HI:`ITB_SEL_LO];
      end
      if (wr_wd) begin
        wd_clock_select_hi_q <= wdata_q[1];
        wd_clock_select_lo_q <= wdata_q[0];
      end
      interval_irq <= interval_flag_q && interval_irq_enable_q;
      counter_clear_strobe <= any_clear;
      // Watchdog cleared with its tap phase only while its select hi bit is zero
      wd_counter_clear <= any_clear && wd_sel_tbt;
      wd_tap_clk <= wd_clock_select_lo_q ? count_d[`ITB_WD_TAP_B] :
                    count_d[`ITB_WD_TAP_A];
      tap_clks <= count_d[23:8];
    end
  end

  // AXI4-Lite write channel
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awaddr_q <= 12'h000;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `ITB_RESP_OKAY;
    end else if (clk_en) begin
      s_axi_awready <= !aw_got_q && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !w_got_q && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        if (awaddr_q[11:2] == `ITB_CTRL_ADDR >> 2) begin
          s_axi_bresp <= `ITB_RESP_OKAY;
        end else if (awaddr_q[11:2] == `ITB_WD_SEL_ADDR >> 2) begin
          s_axi_bresp <= `ITB_RESP_OKAY;
        end else if (awaddr_q[11:2] == `ITB_STATUS_ADDR >> 2) begin
          s_axi_bresp <= `ITB_RESP_OKAY;
        end else begin
          s_axi_bresp <= `ITB_RESP_SLVERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
      end
    end
  end

  // AXI4-Lite read channel
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `ITB_RESP_OKAY;
    end else if (clk_en) begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `ITB_RESP_OKAY;
        if (s_axi_araddr[11:2] == `ITB_CTRL_ADDR >> 2) begin
          // Read-modify-write sees flag as one; clear bit reads zero
          s_axi_rdata <= {24'h000000, interval_flag_q | rmw_read,
                          interval_irq_enable_q, 1'b0, interval_select_q,
                          1'b0};
        end else if (s_axi_araddr[11:2] == `ITB_WD_SEL_ADDR >> 2) begin
          s_axi_rdata <= {30'h00000000, wd_clock_select_hi_q,
                          wd_clock_select_lo_q};
        end else if (s_axi_araddr[11:2] == `ITB_STATUS_ADDR >> 2) begin
          s_axi_rdata <= {8'h00, count_q};
        end else begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= `ITB_RESP_SLVERR;
        end
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule // interval_timebase_timer

// ==== hw/interval_timer_map.vh ====
// Purpose: Register map and constants of the interval time-base timer
// Assumes: 32-bit AXI4-Lite register bus, byte addresses
// Notes: Definitions only
`ifndef INTERVAL_TIMER_MAP_VH
`define INTERVAL_TIMER_MAP_VH

`define ITB_CTRL_OFFSET 12'h00a
`define ITB_CTRL_INDEX 12'h00a
`define ITB_CTRL_ADDR 12'h028
`define ITB_WD_SEL_ADDR 12'h02c
`define ITB_STATUS_ADDR 12'h030
`define ITB_CTRL_RESET 8'h00
`define ITB_BIT_FLAG 7
`define ITB_BIT_IE 6
`define ITB_SEL_HI 4
`define ITB_SEL_LO 1
`define ITB_BIT_CLR 0
`define ITB_CNT_WIDTH 24
`define ITB_CNT_RESET 24'hffffff
`define ITB_TAP_BASE 8
`define ITB_WD_TAP_A 20
`define ITB_WD_TAP_B 19
`define ITB_RESP_OKAY 2'b00
`define ITB_RESP_SLVERR 2'b10

`endif

// ==== testbench/interval_timebase_timer_monitor.sv ====
// Purpose: Port-level checks of the interval time-base timer
// Assumes: aclk single domain, aresetn synchronous active low
// Notes: Bound to every instance of the timer
`timescale 1ns/1ns
module interval_timebase_timer_monitor (
  // Clock and inputs
  input wire aclk,
  input wire aresetn,
  input wire clk_en,
  input wire main_clk_running,
  input wire power_on_clear,
  input wire mode_clear_req,
  // Outputs to neighbours
  input wire counter_clear_strobe,
  input wire wd_counter_clear,
  input wire wd_tap_clk,
  input wire [15:0] tap_clks
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  halt_reload_a: assert property ((clk_en && !main_clk_running)[*3] |->
    tap_clks == 16'hffff) else $error("taps not reloaded on halt");
  halt_still_a: assert property ((clk_en && !main_clk_running)[*3] |=>
    $stable(tap_clks)) else $error("taps move while halted");
  por_reload_a: assert property ((clk_en && power_on_clear)[*3] |->
    tap_clks == 16'hffff) else $error("taps not reloaded on power clear");
  mode_reload_a: assert property ((clk_en && mode_clear_req)[*3] |->
    tap_clks == 16'hffff) else $error("taps not reloaded on mode clear");
  clr_strobe_a: assert property (clk_en && power_on_clear |->
    ##[1:2] counter_clear_strobe) else $error("no clear strobe");
  wd_clear_tie_a: assert property (wd_counter_clear |->
    counter_clear_strobe) else $error("watchdog clear without clear");
  wd_tap_src_a: assert property (wd_tap_clk == tap_clks[12] ||
    wd_tap_clk == tap_clks[11]) else $error("watchdog tap wrong bit");
  restart_taps_a: assert property ($fell(counter_clear_strobe) |->
    tap_clks == 16'hffff) else $error("taps not restarted by clear");
endmodule // interval_timebase_timer_monitor
bind interval_timebase_timer interval_timebase_timer_monitor u_mon (.*);

// ==== testbench/interval_timebase_timer_tb.sv ====
// Purpose: Self-checking bench of the interval time-base timer
// Assumes: 10 MHz aclk, AXI4-Lite master tasks, clk_en tied high
// Notes: Interval select 0 gives a flag every 1024 clocks
`timescale 1ns/1ns
`include "interval_timer_map.vh"
module interval_timebase_timer_tb;
  reg aclk = 0, aresetn = 0, clk_en = 1, main_clk_running = 1;
  reg power_on_clear = 0, mode_clear_req = 0, rmw_read = 0;
  reg [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  reg [31:0] s_axi_wdata = 0;
  reg [3:0] s_axi_wstrb = 4'hf;
  reg s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  reg s_axi_arvalid = 0, s_axi_rready = 0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire s_axi_rvalid, interval_irq, counter_clear_strobe;
  wire wd_counter_clear, wd_tap_clk;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [15:0] tap_clks;
  integer n_fail = 0, n_tests = 0, cyc = 0;
  reg [31:0] d;
  interval_timebase_timer u_dut (.*);
  always #50 aclk = ~aclk;
  task chk(input [31:0] s, input [31:0] e);
    begin
      n_tests = n_tests + 1;
      if (s !== e) begin
        n_fail = n_fail + 1;
        $display("ERROR %0t: got %h want %h", $time, s, e);
      end
    end
  endtask
  task close_out;
    begin
      $display("tests %0d fails %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
    end
  endtask
  task wr(input [11:0] a, input [7:0] v);
    begin
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, v};
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      @(posedge aclk);
      while (!s_axi_bvalid) begin
        if (s_axi_awready) s_axi_awvalid <= 0;
        if (s_axi_wready) s_axi_wvalid <= 0;
        @(posedge aclk);
      end
      chk(s_axi_bresp, `ITB_RESP_OKAY);
      s_axi_bready <= 0;
      @(posedge aclk);
    end
  endtask
  task rd(input [11:0] a, input [1:0] er, output [31:0] v);
    begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      @(posedge aclk);
      while (!s_axi_rvalid) begin
        if (s_axi_arready) s_axi_arvalid <= 0;
        @(posedge aclk);
      end
      v = s_axi_rdata;
      chk(s_axi_rresp, er);
      s_axi_rready <= 0;
      @(posedge aclk);
    end
  endtask
  task t_reset;
    begin
      rd(`ITB_CTRL_ADDR, 0, d);
      chk(d, 0);
      chk(tap_clks, 16'hffff);
      rd(12'h100, `ITB_RESP_SLVERR, d);
      $display("t_reset done");
    end
  endtask
  task t_interval;
    integer k;
    begin
      wr(`ITB_CTRL_ADDR, 8'h00);
      wr(`ITB_CTRL_ADDR, 8'h40);
      wr(`ITB_CTRL_ADDR, 8'h41);
      for (k = 0; k < 1200 && interval_irq !== 1'b1; k = k + 1)
        @(posedge aclk);
      chk(interval_irq, 1);
      rd(`ITB_CTRL_ADDR, 0, d);
      chk(d, 32'hc0);
      wr(`ITB_CTRL_ADDR, 8'h40);
      repeat (2) @(posedge aclk);
      chk(interval_irq, 0);
      rmw_read <= 1;
      rd(`ITB_CTRL_ADDR, 0, d);
      rmw_read <= 0;
      chk(d, 32'hc0);
      $display("t_interval done");
    end
  endtask
  task t_late;
    begin
      wr(`ITB_CTRL_ADDR, 8'h00);
      repeat (1100) @(posedge aclk);
      chk(interval_irq, 0);
      rd(`ITB_CTRL_ADDR, 0, d);
      chk(d, 32'h80);
      wr(`ITB_CTRL_ADDR, 8'hc0);
      repeat (2) @(posedge aclk);
      chk(interval_irq, 1);
      $display("t_late done");
    end
  endtask
  task t_clear;
    begin
      wr(`ITB_CTRL_ADDR, 8'h01);
      chk(wd_tap_clk, 1);
      chk(tap_clks, 16'hffff);
      rd(`ITB_STATUS_ADDR, 0, d);
      chk(d[31:8], 24'h00ffff);
      rd(`ITB_CTRL_ADDR, 0, d);
      chk(d, 0);
      $display("t_clear done");
    end
  endtask
  task t_hw;
    integer i;
    begin
      for (i = 0; i < 3; i = i + 1) begin
        main_clk_running <= (i != 0);
        power_on_clear <= (i == 1);
        mode_clear_req <= (i == 2);
        repeat (4) @(posedge aclk);
        chk(wd_counter_clear, 1);
        chk(counter_clear_strobe, 1);
        rd(`ITB_STATUS_ADDR, 0, d);
        chk(d, 32'hffffff);
      end
      main_clk_running <= 1;
      power_on_clear <= 0;
      mode_clear_req <= 0;
      $display("t_hw done");
    end
  endtask
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail = n_fail + 1;
      close_out;
    end
  end
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1;
    t_reset;
    t_interval;
    t_late;
    t_clear;
    t_hw;
    close_out;
  end
endmodule // interval_timebase_timer_tb
